// ==== dv/pllc_top_asserts.sv ====
`timescale 1ns/1ns
`default_nettype none
module pllc_top_asserts (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic reference_clock_in_tick_i,
  input wire logic sample_clock_direct_tick_i,
  input wire logic sample_clock_tick_o,
  input wire logic pll_power_down_o,
  input wire logic pll_locked_o,
  input wire logic search_busy_o,
  input wire logic [5:0] vco_band_o
);
  // ==========================================================================
  // Shadow of the control register and cycles since its last write.
  logic [7:0] ctrl_r;
  logic [1:0] since_r;
  logic ctrl_wr;
  logic trig;
  assign ctrl_wr = reg_wr_i && (reg_addr_i == pllc_pkg::REG_CTRL_OFS);
  assign trig = ctrl_wr && reg_wdata_i[7] && !reg_wdata_i[6] && ctrl_r[7] && ctrl_r[6];
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_r <= 8'h00;
    end else if (ctrl_wr) begin
      ctrl_r <= reg_wdata_i;
    end
  end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      since_r <= 2'h0;
    end else if (ctrl_wr) begin
      since_r <= 2'h0;
    end else if (since_r != 2'h3) begin
      since_r <= since_r + 2'h1;
    end
  end
  // ==========================================================================
  // Properties.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  property p_bypass;
    pll_power_down_o && $past(pll_power_down_o) |-> sample_clock_tick_o == $past(sample_clock_direct_tick_i);
  endproperty
  a_bypass: assert property (p_bypass) else $error("direct tick not passed");
  property p_en_on;
    ctrl_wr && reg_wdata_i[7] |-> ##2 !pll_power_down_o;
  endproperty
  a_en_on: assert property (p_en_on) else $error("multiplier not powered");
  property p_en_off;
    ctrl_wr && !reg_wdata_i[7] |-> ##2 pll_power_down_o ##1 !search_busy_o;
  endproperty
  a_en_off: assert property (p_en_off) else $error("disable not honoured");
  property p_manual;
    ctrl_r[7] && ctrl_r[6] && since_r == 2'h3 |-> vco_band_o == ctrl_r[5:0];
  endproperty
  a_manual: assert property (p_manual) else $error("manual band not used");
  property p_start;
    trig |-> ##2 search_busy_o;
  endproperty
  a_start: assert property (p_start) else $error("search did not start");
  property p_only_trig;
    $rose(search_busy_o) |-> $past(trig, 2);
  endproperty
  a_only_trig: assert property (p_only_trig) else $error("search without trigger");
  property p_hold;
    !ctrl_r[6] && since_r == 2'h3 && !search_busy_o && !$past(search_busy_o) && !$past(search_busy_o, 2)
      |-> $stable(vco_band_o);
  endproperty
  a_hold: assert property (p_hold) else $error("auto band not held");
  property p_step;
    search_busy_o && $past(search_busy_o)
      |-> vco_band_o == $past(vco_band_o) || vco_band_o == $past(vco_band_o) + 6'h01 || vco_band_o == 6'h00;
  endproperty
  a_step: assert property (p_step) else $error("band search skipped a band");
  property p_unlock;
    search_busy_o |-> !pll_locked_o;
  endproperty
  a_unlock: assert property (p_unlock) else $error("lock during search");
endmodule : pllc_top_asserts
`default_nettype wire

// ==== dv/test_pll_clock_multiplier_control.sv ====
`timescale 1ns/1ns
`default_nettype none
module test_pll_clock_multiplier_control;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic ref_tick = 1'b0;
  logic dir_tick = 1'b0;
  logic sample_tick;
  logic power_down;
  logic locked;
  logic busy;
  logic [5:0] band;
  int errors = 0;
  int check_count = 0;
  int ref_per = 0;
  int dir_per = 0;
  int cyc = 0;
  int n;
  pllc_top u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .reg_wr_i(wr_en), .reg_rd_i(rd_en),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .reference_clock_in_tick_i(ref_tick),
    .sample_clock_direct_tick_i(dir_tick), .sample_clock_tick_o(sample_tick), .pll_power_down_o(power_down),
    .pll_locked_o(locked), .search_busy_o(busy), .vco_band_o(band));
  always #50 clk_i = ~clk_i;
  // ==========================================================================
  // Clock inputs as one-cycle pulses on fixed periods; a period of 0 keeps them quiet.
  always @(negedge clk_i) begin
    cyc <= cyc + 1;
    ref_tick <= (ref_per != 0) && (cyc % ref_per == 0);
    dir_tick <= (dir_per != 0) && (cyc % dir_per == 0);
  end
  // ==========================================================================
  // Access tasks and checks.
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    wr_en = 1'b1;
    addr = a;
    wdata = d;
    @(negedge clk_i);
    wr_en = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk_i);
    rd_en = 1'b1;
    addr = a;
    @(negedge clk_i);
    rd_en = 1'b0;
    chk("rdata", exp, rdata);
  endtask : rd
  task automatic count(input int k);
    n = 0;
    repeat (k) begin
      @(negedge clk_i);
      n += sample_tick;
    end
  endtask : count
  task automatic wait_busy(input logic lvl, input int lim);
    for (int i = 0; i < lim && busy !== lvl; i++) @(negedge clk_i);
    chk("search_busy", {7'h00, lvl}, {7'h00, busy});
  endtask : wait_busy
  task automatic conclude();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : conclude
  // ==========================================================================
  // Watchdog: the search should settle well inside this span.
  initial begin
    #6000000;
    errors++;
    conclude();
  end
  initial begin : main
    repeat (3) @(negedge clk_i);
    rst_n_i = 1'b1;
    repeat (3) @(posedge clk_i);
    rd(8'h12, pllc_pkg::CTRL_RST);
    rd(8'h14, pllc_pkg::LOOP_RST);
    rd(8'h15, pllc_pkg::DIV_RST);
    rd(8'h20, 8'h00);
    chk("power_down", 8'h01, {7'h00, power_down});
    dir_per = 3;
    @(negedge clk_i);
    count(30);
    chk("direct ticks", 8'h0A, n[7:0]);
    wr(8'h15, 8'hC2);
    wr(8'h14, 8'hE7);
    rd(8'h15, 8'hC2);
    wr(8'h12, 8'h15);
    wr(8'h12, 8'h55);
    wr(8'h12, 8'hD5);
    wr(8'h12, 8'hD5);
    repeat (3) @(negedge clk_i);
    chk("manual band", 8'h15, {2'b00, band});
    chk("power_down", 8'h00, {7'h00, power_down});
    rd(8'h12, 8'hD5);
    wr(8'h12, 8'h00);
    wr(8'h15, 8'h02);
    ref_per = 170;
    wr(8'h12, 8'hC0);
    wr(8'h12, 8'h80);
    wait_busy(1'b1, 4);
    wait_busy(1'b0, 40000);
    chk("band range", 8'h01, {7'h00, band >= 6'h0C && band <= 6'h0E});
    for (int i = 0; i < 20000 && locked !== 1'b1; i++) @(negedge clk_i);
    chk("locked", 8'h01, {7'h00, locked});
    count(1360);
    chk("ticks per 8 refs", 8'h01, {7'h00, n >= 7 && n <= 9});
    wr(8'h12, 8'h80);
    repeat (4) @(negedge clk_i);
    chk("no restart", 8'h00, {7'h00, busy});
    conclude();
  end
endmodule : test_pll_clock_multiplier_control
bind pllc_top pllc_top_asserts u_chk (.clk_i(clk_i), .rst_n_i(rst_n_i), .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
  .reference_clock_in_tick_i(reference_clock_in_tick_i), .sample_clock_direct_tick_i(sample_clock_direct_tick_i),
  .sample_clock_tick_o(sample_clock_tick_o), .pll_power_down_o(pll_power_down_o), .pll_locked_o(pll_locked_o),
  .search_busy_o(search_busy_o), .vco_band_o(vco_band_o));
`default_nettype wire

// ==== include/pllc_pkg.sv ====
`default_nettype none
package pllc_pkg;
  // ==========================================================================
  // Register map.
  localparam logic [7:0] REG_CTRL_OFS = 8'h12;
  localparam logic [7:0] REG_LOOP_OFS = 8'h14;
  localparam logic [7:0] REG_DIV_OFS = 8'h15;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] LOOP_RST = 8'hE7;
  localparam logic [7:0] DIV_RST = 8'h00;
  // ==========================================================================
  // Field positions.
  localparam int CTRL_EN_BIT = 7;
  localparam int CTRL_MAN_BIT = 6;
  localparam int DIV_CROSS_BIT = 4;
  localparam int DIV_LOOP_LSB = 6;
  localparam int DIV_VCO_LSB = 0;
  // ==========================================================================
  // Band and loop constants.
  localparam int BAND_COUNT = 64;
  localparam logic [5:0] BAND_LAST = 6'h3F;
  localparam logic [8:0] BAND_BASE = 9'h0C8;
  localparam logic [8:0] BAND_STEP = 9'h003;
  localparam logic [3:0] FINE_MID = 4'h8;
  localparam logic [3:0] FINE_MAX = 4'hF;
  localparam logic [3:0] FINE_MIN = 4'h0;
  localparam logic [3:0] SEARCH_WINDOW = 4'h8;
  localparam logic [1:0] LOCK_HITS = 2'h3;
endpackage : pllc_pkg
`default_nettype wire

// ==== logic/pllc_div.sv ====
`timescale 1ns/1ns
`default_nettype none
module pllc_div #(
  parameter int W = 4
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic clear_i,
  input wire logic tick_i,
  input wire logic [W-1:0] ratio_i,
  output logic tick_o
);
  logic [W-1:0] cnt_r;
  logic last;

  // A ratio of zero behaves as one, so a divider never stalls the chain.
  assign last = (cnt_r >= ratio_i - W'(1)) || (ratio_i == '0);
  assign tick_o = tick_i && last;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r <= '0;
    end else if (clear_i) begin
      cnt_r <= '0;
    end else if (tick_i) begin
      cnt_r <= last ? '0 : cnt_r + W'(1);
    end
  end
endmodule : pllc_div
`default_nettype wire

// ==== logic/pllc_top.sv ====
// Function
// - Enable set: sample clock comes from the multiplied reference; direct input ignored.
// - Enable clear: multiplier powered down, sample clock taken from direct input.
// - VCO rate equals reference rate times loop ratio times VCO ratio.
// - Sample clock equals reference times loop ratio; VCO divider feeds loop divider.
// - VCO offers 64 overlapping bands; best code is found per device.
// - Writing control 0xC0 then 0x80 runs the automatic band search.
// - Chosen band holds lock over temperature; fine loop tracks drift without rebanding.
// - Manual mode uses the written band code directly as VCO band.
`timescale 1ns/1ns
`default_nettype none
module pllc_top (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  input wire logic reference_clock_in_tick_i,
  input wire logic sample_clock_direct_tick_i,
  output logic sample_clock_tick_o,
  output logic pll_power_down_o,
  output logic pll_locked_o,
  output logic search_busy_o,
  output logic [5:0] vco_band_o
);
  // ==========================================================================
  // Reset synchroniser.
  logic rst_meta_r;
  logic rst_sync_r;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  // ==========================================================================
  // Register file.
  logic [7:0] ctrl_r;
  logic [7:0] loop_r;
  logic [7:0] div_r;
  logic wr_ctrl;
  logic start_search;
  assign wr_ctrl = reg_wr_i && (reg_addr_i == pllc_pkg::REG_CTRL_OFS);
  // Only a manual-to-automatic change while enabled launches a search.
  assign start_search = wr_ctrl && ctrl_r[pllc_pkg::CTRL_EN_BIT] && ctrl_r[pllc_pkg::CTRL_MAN_BIT] &&
                        reg_wdata_i[pllc_pkg::CTRL_EN_BIT] && !reg_wdata_i[pllc_pkg::CTRL_MAN_BIT];

  always_ff @(posedge clk_i or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      ctrl_r <= pllc_pkg::CTRL_RST;
      loop_r <= pllc_pkg::LOOP_RST;
      div_r <= pllc_pkg::DIV_RST;
    end else if (reg_wr_i) begin
      if (reg_addr_i == pllc_pkg::REG_CTRL_OFS) ctrl_r <= reg_wdata_i;
      if (reg_addr_i == pllc_pkg::REG_LOOP_OFS) loop_r <= reg_wdata_i;
      if (reg_addr_i == pllc_pkg::REG_DIV_OFS) div_r <= reg_wdata_i;
    end
  end

  logic enable;
  logic manual;
  assign enable = ctrl_r[pllc_pkg::CTRL_EN_BIT];
  assign manual = ctrl_r[pllc_pkg::CTRL_MAN_BIT];

  // ==========================================================================
  // Divide ratio decoding.
  function automatic logic [3:0] loop_ratio(input logic [1:0] code);
    loop_ratio = 4'h1 << code;
  endfunction : loop_ratio

  function automatic logic [3:0] vco_ratio(input logic [1:0] code);
    unique case (code)
      2'h0: vco_ratio = 4'h4;
      2'h1: vco_ratio = 4'h2;
      default: vco_ratio = 4'h1;
    endcase
  endfunction : vco_ratio

  logic [3:0] loop_divide_ratio;
  logic [3:0] vco_divide_ratio;
  assign loop_divide_ratio = loop_ratio(div_r[pllc_pkg::DIV_LOOP_LSB +: 2]);
  assign vco_divide_ratio = vco_ratio(div_r[pllc_pkg::DIV_VCO_LSB +: 2]);

  // ==========================================================================
  // Band search state machine.
  typedef enum logic [1:0] {
    PLLC_IDLE = 2'b01,
    PLLC_MEASURE = 2'b10
  } pllc_state_e;

  pllc_state_e state_r;
  logic [5:0] auto_band_r;
  logic [3:0] win_ref_r;
  logic [4:0] win_fb_r;
  logic fb_tick;
  logic [5:0] band_sel;
  logic searching;
  logic win_restart;
  assign searching = (state_r == PLLC_MEASURE);
  // Each measuring window restarts the divider chain from a known phase.
  // Otherwise a free-running phase lets a slow band score a full window and stop the search early.
  assign win_restart = (start_search && !searching) ||
                       (searching && reference_clock_in_tick_i && (win_ref_r == pllc_pkg::SEARCH_WINDOW - 4'h1));
  // Manual mode feeds the written code straight to the VCO.
  assign band_sel = manual ? ctrl_r[5:0] : auto_band_r;

  always_ff @(posedge clk_i or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      state_r <= PLLC_IDLE;
      auto_band_r <= 6'h00;
      win_ref_r <= 4'h0;
      win_fb_r <= 5'h00;
    end else if (!enable) begin
      state_r <= PLLC_IDLE;
    end else begin
      unique case (state_r)
        PLLC_IDLE: begin
          if (start_search) begin
            state_r <= PLLC_MEASURE;
            auto_band_r <= 6'h00;
            win_ref_r <= 4'h0;
            win_fb_r <= 5'h00;
          end
        end
        PLLC_MEASURE: begin
          if (fb_tick && (win_fb_r != 5'h1F)) win_fb_r <= win_fb_r + 5'h01;
          if (reference_clock_in_tick_i) begin
            if (win_ref_r == pllc_pkg::SEARCH_WINDOW - 4'h1) begin
              // The first band fast enough keeps the fine loop near mid-range,
              // which leaves headroom for temperature drift in both directions.
              if ((win_fb_r >= {1'b0, pllc_pkg::SEARCH_WINDOW}) || (auto_band_r == pllc_pkg::BAND_LAST)) begin
                state_r <= PLLC_IDLE;
              end else begin
                auto_band_r <= auto_band_r + 6'h01;
              end
              win_ref_r <= 4'h0;
              win_fb_r <= 5'h00;
            end else begin
              win_ref_r <= win_ref_r + 4'h1;
            end
          end
        end
      endcase
    end
  end

  // ==========================================================================
  // VCO model and fine tracking loop.
  logic [3:0] fine_r;
  logic [1:0] fb_seen_r;
  logic [1:0] hits_r;
  logic [8:0] vco_period;
  logic vco_tick;
  logic div_tick;
  assign vco_period = pllc_pkg::BAND_BASE - 9'(band_sel * pllc_pkg::BAND_STEP) + {5'h00, fine_r};

  always_ff @(posedge clk_i or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      fine_r <= pllc_pkg::FINE_MID;
      fb_seen_r <= 2'h0;
      hits_r <= 2'h0;
    end else if (!enable || searching) begin
      fine_r <= pllc_pkg::FINE_MID;
      fb_seen_r <= 2'h0;
      hits_r <= 2'h0;
    end else if (reference_clock_in_tick_i) begin
      // One feedback edge per reference edge means the loop is in balance.
      fb_seen_r <= 2'h0;
      if (fb_seen_r > 2'h1) begin
        if (fine_r != pllc_pkg::FINE_MAX) fine_r <= fine_r + 4'h1;
        hits_r <= 2'h0;
      end else if (fb_seen_r == 2'h0) begin
        if (fine_r != pllc_pkg::FINE_MIN) fine_r <= fine_r - 4'h1;
        hits_r <= 2'h0;
      end else if (hits_r != pllc_pkg::LOCK_HITS) begin
        hits_r <= hits_r + 2'h1;
      end
    end else if (fb_tick && (fb_seen_r != 2'h3)) begin
      fb_seen_r <= fb_seen_r + 2'h1;
    end
  end

  pllc_div #(.W(9)) u_vco (
    .clk_i(clk_i),
    .rst_n_i(rst_sync_r),
    .clear_i(!enable || win_restart),
    .tick_i(1'b1),
    .ratio_i(vco_period),
    .tick_o(vco_tick)
  );

  pllc_div #(.W(4)) u_vco_div (
    .clk_i(clk_i),
    .rst_n_i(rst_sync_r),
    .clear_i(!enable || win_restart),
    .tick_i(vco_tick),
    .ratio_i(vco_divide_ratio),
    .tick_o(div_tick)
  );

  pllc_div #(.W(4)) u_loop_div (
    .clk_i(clk_i),
    .rst_n_i(rst_sync_r),
    .clear_i(!enable || win_restart),
    .tick_i(div_tick),
    .ratio_i(loop_divide_ratio),
    .tick_o(fb_tick)
  );

  // ==========================================================================
  // Outputs and read-back.
  always_ff @(posedge clk_i or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      sample_clock_tick_o <= 1'b0;
      pll_power_down_o <= 1'b1;
      pll_locked_o <= 1'b0;
      search_busy_o <= 1'b0;
      vco_band_o <= 6'h00;
    end else begin
      sample_clock_tick_o <= enable ? div_tick : sample_clock_direct_tick_i;
      pll_power_down_o <= !enable;
      pll_locked_o <= enable && !searching && (hits_r == pllc_pkg::LOCK_HITS);
      search_busy_o <= searching;
      vco_band_o <= band_sel;
    end
  end

  always_ff @(posedge clk_i or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      unique case (reg_addr_i)
        pllc_pkg::REG_CTRL_OFS: reg_rdata_o <= {ctrl_r[7:6], band_sel};
        pllc_pkg::REG_LOOP_OFS: reg_rdata_o <= loop_r;
        pllc_pkg::REG_DIV_OFS: reg_rdata_o <= div_r;
        default: reg_rdata_o <= 8'h00;
      endcase
    end
  end
endmodule : pllc_top
`default_nettype wire
